// ===== common/jbs_pkg.sv
// Shared constants and types for the boundary-scan test access block
package jbs_pkg;

   // Instruction register and data register widths
   localparam int IR_LEN      = 10;
   localparam int UCODE_LEN   = 32;
   localparam int IDCODE_LEN  = 32;

   // Instruction codes
   localparam logic [9:0] IR_SAMPLE   = 10'h005;
   localparam logic [9:0] IR_EXTEST   = 10'h00F;
   localparam logic [9:0] IR_BYPASS   = 10'h3FF;
   localparam logic [9:0] IR_USERCODE = 10'h007;
   localparam logic [9:0] IR_IDCODE   = 10'h006;
   localparam logic [9:0] IR_HIGHZ    = 10'h00B;
   localparam logic [9:0] IR_CLAMP    = 10'h00A;
   localparam logic [9:0] IR_RECONFIG = 10'h001;
   localparam logic [9:0] IR_IOSTD    = 10'h00D;
   // Vendor configuration-load and analyzer codes are not published; neutral picks
   localparam logic [9:0] IR_CFG_LOAD = 10'h002;
   localparam logic [9:0] IR_CFG_DATA = 10'h003;
   localparam logic [9:0] IR_ANALYZER = 10'h00E;

   // Capture pattern for the instruction register (low bits 01 as usual)
   localparam logic [9:0] IR_CAPTURE  = 10'h001;

   // Identification field widths
   localparam int ID_VER_W  = 4;
   localparam int ID_PART_W = 16;
   localparam int ID_MFR_W  = 11;

   // Pin sampling
   localparam int SYNC_STAGES = 2;

   // Controller states
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
      ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } jbs_state_type;

   // Serial link pins sampled from the tester
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jbs_link_type;

endpackage

// ===== design/jbs_tap.sv
// Boundary-scan test access port with instruction decode and data register routing
`timescale 1ns/1ps
`default_nettype none
module jbs_tap #(
   parameter int                 BSR_LEN  = 24,           // Drive, enable and input cell per pin
   parameter int                 NPINS    = 8,            // User pins covered by the chain
   parameter int                 IOSTD_LEN = 16,          // Pin standard chain length
   parameter logic [3:0]         ID_VER   = 4'h0,         // Arbitrary value
   parameter logic [15:0]        ID_PART  = 16'h1234,     // Arbitrary value
   parameter logic [10:0]        ID_MFR   = 11'h055,      // Arbitrary value
   parameter logic [31:0]        USERCODE = 32'hFFFF_FFFF // Loaded user code
) (
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 arst_n,
   // Test port pins
   input  wire logic                 tck,
   input  wire logic                 tms,
   input  wire logic                 tdi,
   output logic                      tdo,
   output logic                      tdo_oe,
   // Core side of user pins
   input  wire logic [NPINS-1:0]     core_out,
   input  wire logic [NPINS-1:0]     core_oe,
   input  wire logic [NPINS-1:0]     pin_in,
   input  wire logic [NPINS-1:0]     hold_en,
   output logic      [NPINS-1:0]     pin_out,
   output logic      [NPINS-1:0]     pin_oe,
   output logic      [NPINS-1:0]     pin_keep,
   // Configuration engine
   input  wire logic                 cfg_busy,
   input  wire logic                 cfg_done,
   output logic                      reconfig_req,
   output logic                      cfg_abort,
   output logic                      config_status_n_oe,
   output logic                      cfg_load_sel,
   output logic                      cfg_data_sel,
   output logic                      analyzer_sel,
   output logic                      cfg_shift_bit,
   output logic                      cfg_shift_en,
   output logic      [IOSTD_LEN-1:0] io_std
);
   // Synchronisers for the test pins; first stage feeds only the second
   jbs_pkg::jbs_link_type sync1_r;
   jbs_pkg::jbs_link_type sync2_r;
   logic                  tck_d_r;     // Previous sampled clock, for edge finding
   logic                  tck_rise;
   logic                  tck_fall;
   logic [NPINS-1:0]      pin_s1_r;    // Pin levels, first sampling stage
   logic [NPINS-1:0]      pin_s2_r;    // Pin levels, safe to capture
   // Controller and registers
   jbs_pkg::jbs_state_type st_r;
   jbs_pkg::jbs_state_type st_nxt;
   logic [jbs_pkg::IR_LEN-1:0]     ir_sh_r;   // Instruction shift stage
   logic [jbs_pkg::IR_LEN-1:0]     ir_r;      // Active instruction
   logic [BSR_LEN-1:0]             bsr_sh_r;  // Boundary shift stage
   logic [BSR_LEN-1:0]             bsr_up_r;  // Boundary update latch
   logic [31:0]                    dr32_r;    // Shared user code / ident shifter
   logic                           byp_r;     // One-bit bypass stage
   logic [IOSTD_LEN-1:0]           iostd_sh_r;
   logic [IOSTD_LEN-1:0]           iostd_r;
   logic                           status_low_r;
   logic                           cfg_bit_r;
   logic [31:0]                    idcode;
   // Decoded instruction
   logic sel_bsr, sel_32, sel_ioc, sel_cfg, force_z, force_bsr, is_id;
   // Two-flop sampling of the tester pins
   // four pin port
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         tck_d_r <= 1'b0;
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end
      else
      begin
         sync1_r <= '{tck: tck, tms: tms, tdi: tdi};
         sync2_r <= sync1_r;
         tck_d_r <= sync2_r.tck;
         // Pin levels are asynchronous to the core clock as well
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end
   // Edges of the sampled test clock; link runs 12.5x slower than core
   assign tck_rise = sync2_r.tck & ~tck_d_r;
   assign tck_fall = ~sync2_r.tck & tck_d_r;
   assign idcode = {ID_VER, ID_PART, ID_MFR, 1'b1};
   // Instruction decode
   always_comb
   begin
      sel_bsr   = 1'b0;
      sel_32    = 1'b0;
      sel_ioc   = 1'b0;
      sel_cfg   = 1'b0;
      force_z   = 1'b0;
      force_bsr = 1'b0;
      is_id     = 1'b0;
      unique case (ir_r)
         jbs_pkg::IR_SAMPLE:   sel_bsr = 1'b1;
         jbs_pkg::IR_EXTEST:
         begin
            sel_bsr   = 1'b1;
            force_bsr = 1'b1;
         end
         jbs_pkg::IR_USERCODE: sel_32 = 1'b1;
         jbs_pkg::IR_IDCODE:
         begin
            sel_32 = 1'b1;
            is_id  = 1'b1;
         end
         jbs_pkg::IR_HIGHZ:    force_z = 1'b1;
         jbs_pkg::IR_CLAMP:    force_bsr = 1'b1;
         jbs_pkg::IR_IOSTD:    sel_ioc = 1'b1;
         jbs_pkg::IR_CFG_DATA: sel_cfg = 1'b1;
         // bypass; others fall back to bypass
         default:              sel_bsr = 1'b0;
      endcase
   end
   // Next controller state, standard sixteen-state walk on TMS
   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r)
         jbs_pkg::ST_RESET:  st_nxt = sync2_r.tms ? jbs_pkg::ST_RESET  : jbs_pkg::ST_IDLE;
         jbs_pkg::ST_IDLE:   st_nxt = sync2_r.tms ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
         jbs_pkg::ST_SEL_DR: st_nxt = sync2_r.tms ? jbs_pkg::ST_SEL_IR : jbs_pkg::ST_CAP_DR;
         jbs_pkg::ST_CAP_DR: st_nxt = sync2_r.tms ? jbs_pkg::ST_EX1_DR : jbs_pkg::ST_SH_DR;
         jbs_pkg::ST_SH_DR:  st_nxt = sync2_r.tms ? jbs_pkg::ST_EX1_DR : jbs_pkg::ST_SH_DR;
         jbs_pkg::ST_EX1_DR: st_nxt = sync2_r.tms ? jbs_pkg::ST_UPD_DR : jbs_pkg::ST_PAU_DR;
         jbs_pkg::ST_PAU_DR: st_nxt = sync2_r.tms ? jbs_pkg::ST_EX2_DR : jbs_pkg::ST_PAU_DR;
         jbs_pkg::ST_EX2_DR: st_nxt = sync2_r.tms ? jbs_pkg::ST_UPD_DR : jbs_pkg::ST_SH_DR;
         jbs_pkg::ST_UPD_DR: st_nxt = sync2_r.tms ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
         jbs_pkg::ST_SEL_IR: st_nxt = sync2_r.tms ? jbs_pkg::ST_RESET  : jbs_pkg::ST_CAP_IR;
         jbs_pkg::ST_CAP_IR: st_nxt = sync2_r.tms ? jbs_pkg::ST_EX1_IR : jbs_pkg::ST_SH_IR;
         jbs_pkg::ST_SH_IR:  st_nxt = sync2_r.tms ? jbs_pkg::ST_EX1_IR : jbs_pkg::ST_SH_IR;
         jbs_pkg::ST_EX1_IR: st_nxt = sync2_r.tms ? jbs_pkg::ST_UPD_IR : jbs_pkg::ST_PAU_IR;
         jbs_pkg::ST_PAU_IR: st_nxt = sync2_r.tms ? jbs_pkg::ST_EX2_IR : jbs_pkg::ST_PAU_IR;
         jbs_pkg::ST_EX2_IR: st_nxt = sync2_r.tms ? jbs_pkg::ST_UPD_IR : jbs_pkg::ST_SH_IR;
         jbs_pkg::ST_UPD_IR: st_nxt = sync2_r.tms ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
      endcase
   end
   // Controller advances on each sampled rising edge
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         st_r <= jbs_pkg::ST_RESET;
      else if (tck_rise)
         st_r <= st_nxt;
   end
   // Instruction register: capture, shift, update; reset loads identification
   // ten-bit instruction
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ir_sh_r <= '0;
         ir_r    <= jbs_pkg::IR_IDCODE;
      end
      else if (tck_rise)
      begin
         if (st_r == jbs_pkg::ST_CAP_IR)
            ir_sh_r <= jbs_pkg::IR_CAPTURE;
         else if (st_r == jbs_pkg::ST_SH_IR)
            ir_sh_r <= {sync2_r.tdi, ir_sh_r[jbs_pkg::IR_LEN-1:1]};
      end
      else if (tck_fall)
      begin
         // Update on the falling edge, as the standard asks
         if (st_r == jbs_pkg::ST_RESET)
            ir_r <= jbs_pkg::IR_IDCODE;
         else if (st_r == jbs_pkg::ST_UPD_IR)
            ir_r <= ir_sh_r;
      end
   end
   // Boundary chain: capture pins, shift, update on falling edge
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bsr_sh_r <= '0;
         bsr_up_r <= '0;
      end
      else if (tck_rise && sel_bsr)
      begin
         if (st_r == jbs_pkg::ST_CAP_DR)
            bsr_sh_r <= BSR_LEN'({pin_s2_r, core_oe, core_out});
         else if (st_r == jbs_pkg::ST_SH_DR)
            bsr_sh_r <= {sync2_r.tdi, bsr_sh_r[BSR_LEN-1:1]};
      end
      else if (tck_fall && sel_bsr && st_r == jbs_pkg::ST_UPD_DR)
         bsr_up_r <= bsr_sh_r;
   end
   // Shared 32-bit shifter for user code and identification, plus bypass
   // user code load
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dr32_r <= '0;
         byp_r  <= 1'b0;
      end
      else if (tck_rise)
      begin
         if (st_r == jbs_pkg::ST_CAP_DR)
         begin
            dr32_r <= is_id ? idcode : USERCODE;
            byp_r  <= 1'b0;
         end
         else if (st_r == jbs_pkg::ST_SH_DR)
         begin
            dr32_r <= {sync2_r.tdi, dr32_r[31:1]};
            byp_r  <= sync2_r.tdi;
         end
      end
   end
   // Pin standard chain: shifted, then applied on update
   // accepted in any configuration phase
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         iostd_sh_r <= '0;
         iostd_r    <= '0;
      end
      else if (tck_rise && sel_ioc && st_r == jbs_pkg::ST_SH_DR)
         iostd_sh_r <= {sync2_r.tdi, iostd_sh_r[IOSTD_LEN-1:1]};
      else if (tck_fall && sel_ioc && st_r == jbs_pkg::ST_UPD_DR)
         iostd_r <= iostd_sh_r;
   end
   // Status low latch; a new issue wins over completion in the same cycle
   // hold status low
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         status_low_r <= 1'b0;
      else if (sel_ioc)
         status_low_r <= 1'b1;
      else if (cfg_done)
         status_low_r <= 1'b0;
   end
   // Serial configuration bit handed to the loader
   // configuration data shift
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         cfg_bit_r <= 1'b0;
      else if (tck_rise && sel_cfg && st_r == jbs_pkg::ST_SH_DR)
         cfg_bit_r <= sync2_r.tdi;
   end
   // One-cycle reconfiguration pulse when the instruction is run
   // internal reconfiguration, pin untouched
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         reconfig_req <= 1'b0;
      else
         reconfig_req <= tck_fall && st_r == jbs_pkg::ST_UPD_IR && ir_sh_r == jbs_pkg::IR_RECONFIG;
   end
   // Serial output, changed on falling edge, enabled only while shifting
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo_oe <= (st_r == jbs_pkg::ST_SH_DR) || (st_r == jbs_pkg::ST_SH_IR);
         if (st_r == jbs_pkg::ST_SH_IR)
            tdo <= ir_sh_r[0];
         else if (sel_bsr)
            tdo <= bsr_sh_r[0];
         else if (sel_32)
            tdo <= dr32_r[0];
         else if (sel_ioc)
            tdo <= iostd_sh_r[0];
         else
            tdo <= byp_r;
      end
   end
   // Pin muxing per user pin; float beats clamp, clamp beats core drive
   // hold adds a keeper on forced pins left undriven; float and enable stay forced
   for (genvar i = 0; i < NPINS; i++)
   begin : g_pin
      assign pin_out[i]  = force_z ? 1'b0 : (force_bsr ? bsr_up_r[i % BSR_LEN] : core_out[i]);
      assign pin_oe[i]   = force_z ? 1'b0 : (force_bsr ? bsr_up_r[(i + NPINS) % BSR_LEN] : core_oe[i]);
      assign pin_keep[i] = hold_en[i] & (force_z | force_bsr) & ~pin_oe[i];
   end
   // Configuration side outputs
   // abort running load
   assign cfg_abort          = sel_ioc & cfg_busy;
   assign config_status_n_oe = status_low_r;
   // load selects are the tester's to time around configuration
   assign cfg_load_sel       = (ir_r == jbs_pkg::IR_CFG_LOAD);
   assign cfg_data_sel       = sel_cfg;
   assign analyzer_sel       = (ir_r == jbs_pkg::IR_ANALYZER);
   assign cfg_shift_bit      = cfg_bit_r;
   assign cfg_shift_en       = sel_cfg & (st_r == jbs_pkg::ST_SH_DR);
   assign io_std             = iostd_r;
endmodule
`default_nettype wire

// ===== tb/jbs_tap_properties.sv
// Port-level assertions for the boundary-scan block
`timescale 1ns/1ps
`default_nettype none

module jbs_tap_properties #(
   parameter int NPINS = 8
) (
   // Clock, reset and watched ports
   input wire logic             core_clk,
   input wire logic             arst_n,
   input wire logic             tck,
   input wire logic             tdo,
   input wire logic             tdo_oe,
   input wire logic [NPINS-1:0] hold_en,
   input wire logic [NPINS-1:0] pin_keep,
   input wire logic             cfg_busy,
   input wire logic             cfg_done,
   input wire logic             reconfig_req,
   input wire logic             cfg_abort,
   input wire logic             config_status_n_oe,
   input wire logic             cfg_load_sel,
   input wire logic             cfg_data_sel,
   input wire logic             analyzer_sel,
   input wire logic             cfg_shift_en
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   property p_abort_busy;
      cfg_abort |-> cfg_busy;
   endproperty
   a_abort_busy: assert property (p_abort_busy) else $error("abort without a running load");

   property p_status_hold;
      config_status_n_oe && !cfg_done |=> config_status_n_oe;
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status released early");

   // Pulse lands in the low phase after the update fall
   property p_pulse;
      reconfig_req |-> !tck ##1 !reconfig_req;
   endproperty
   a_pulse: assert property (p_pulse) else $error("reconfiguration pulse malformed");

   property p_shift_sel;
      cfg_shift_en |-> cfg_load_sel || cfg_data_sel;
   endproperty
   a_shift_sel: assert property (p_shift_sel) else $error("load shift without load code");

   property p_sel_onehot;
      $onehot0({cfg_load_sel, cfg_data_sel, analyzer_sel, cfg_abort});
   endproperty
   a_sel_onehot: assert property (p_sel_onehot) else $error("two vendor selects at once");

   property p_keep_hold;
      (pin_keep & ~hold_en) == '0;
   endproperty
   a_keep_hold: assert property (p_keep_hold) else $error("keeper on a pin without hold");

   // Output moves only after a fall, so it is quiet in the high phase
   property p_tdo_steady;
      tck [*4] |-> $stable(tdo);
   endproperty
   a_tdo_steady: assert property (p_tdo_steady) else $error("serial out moved with clock high");

   // Enable is registered off the sampled fall: pin low now, high four samples back
   property p_oe_rise;
      $rose(tdo_oe) |-> !tck && $past(tck, 4);
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("output enable not after a fall");

   // Main scenarios reached
   c_reconfig: cover property (reconfig_req);
   c_abort: cover property (cfg_abort);
   c_release: cover property ($fell(config_status_n_oe));
endmodule

bind jbs_tap jbs_tap_properties #(.NPINS(NPINS)) u_props (
   .core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
   .hold_en(hold_en), .pin_keep(pin_keep), .cfg_busy(cfg_busy), .cfg_done(cfg_done),
   .reconfig_req(reconfig_req), .cfg_abort(cfg_abort), .config_status_n_oe(config_status_n_oe),
   .cfg_load_sel(cfg_load_sel), .cfg_data_sel(cfg_data_sel), .analyzer_sel(analyzer_sel),
   .cfg_shift_en(cfg_shift_en)
);

`default_nettype wire

// ===== tb/jbs_tester.sv
// Behavioural test controller that walks the scan port over its four pins
`timescale 1ns/1ps
`default_nettype none

module jbs_tester (
   // Test port pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // Pins rest at their pull levels; the clock stands still between frames
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // One 125 ns period; tdo is taken at the rising edge, before the shift
   task automatic pulse(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #62.5 tck = 1'b1;
      q = tdo;
      #62.5 tck = 1'b0;
   endtask

   // Five high mode bits reach reset from anywhere, then park in idle
   task automatic to_idle;
      logic q;
      repeat (5) pulse(1'b1, 1'b1, q);
      pulse(1'b0, 1'b1, q);
   endtask

   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      pulse(1'b1, 1'b1, q);
      // Instruction path takes one extra select step
      if (ir)
         pulse(1'b1, 1'b1, q);
      pulse(1'b0, 1'b1, q);
      pulse(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++)
      begin
         pulse(i == n - 1, din[i], q);
         dout[i] = q;
      end
      pulse(1'b1, 1'b1, q);
      pulse(1'b0, 1'b1, q);
      // Released lines fall back to the pull-up
      tms = 1'b1;
      tdi = 1'b1;
   endtask
endmodule

`default_nettype wire

// ===== tb/test_jbs_tap.sv
// Self-checking bench for the boundary-scan block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module test_jbs_tap;
   // Arbitrary identity and user code values
   localparam logic [3:0]  VER   = 4'h9;
   localparam logic [15:0] PART  = 16'h4c3b;
   localparam logic [10:0] MFR   = 11'h2a5;
   localparam logic [31:0] UCODE = 32'h1357_9bdf;
   localparam logic [9:0]  BYP [3] = '{jbs_pkg::IR_BYPASS, jbs_pkg::IR_HIGHZ, jbs_pkg::IR_CLAMP};
   localparam logic [9:0]  VEN [3] = '{jbs_pkg::IR_CFG_LOAD, jbs_pkg::IR_CFG_DATA, jbs_pkg::IR_ANALYZER};

   logic core_clk, arst_n, tck, tms, tdi, tdo, cfg_busy, cfg_done, reconfig_req, cfg_abort;
   logic [7:0]  core_out, core_oe, pin_in, hold_en, pin_out, pin_oe, pin_keep;
   logic        status_oe, load_sel, data_sel, ana_sel, shift_bit;
   logic [15:0] io_std;
   logic [31:0] seed, got, pat;
   logic [9:0]  code;
   int          n_fail, checks_done, cycles, n_pulse;

   jbs_tap #(.BSR_LEN(24), .NPINS(8), .IOSTD_LEN(16), .ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR),
      .USERCODE(UCODE)) dut (
      .core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(),
      .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in), .hold_en(hold_en), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_keep(pin_keep), .cfg_busy(cfg_busy), .cfg_done(cfg_done),
      .reconfig_req(reconfig_req), .cfg_abort(cfg_abort), .config_status_n_oe(status_oe),
      .cfg_load_sel(load_sel), .cfg_data_sel(data_sel), .analyzer_sel(ana_sel), .cfg_shift_bit(shift_bit),
      .cfg_shift_en(), .io_std(io_std));

   jbs_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   // Fixed-seed xorshift keeps runs repeatable
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Bypass captures zero, then echoes one clock late
   function automatic logic [7:0] byp_exp(input logic [7:0] d);
      return {d[6:0], 1'b0};
   endfunction

   task automatic settle;
      repeat (6) @(negedge core_clk);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always #5 core_clk = ~core_clk;

   // Pulse counter and hang guard; ceiling is about four and a half times the run
   always @(posedge core_clk)
   begin
      if (reconfig_req === 1'b1)
         n_pulse++;
      cycles++;
      if (cycles == 30000)
      begin
         n_fail++;
         report_and_stop();
      end
   end

   initial
   begin
      {core_clk, arst_n, cfg_busy, cfg_done} = '0;
      {core_out, core_oe, pin_in, hold_en} = '0;
      {n_fail, checks_done, cycles, n_pulse} = '0;
      seed = 32'h0000_04a2;
      repeat (16) @(posedge core_clk);
      pat = rnd();
      arst_n <= 1'b1;
      {hold_en, pin_in, core_oe, core_out} <= pat;
      @(posedge core_clk);
      u_tst.to_idle();
      u_tst.scan(1'b0, 32, rnd(), got);
      `CHK("idcode", {VER, PART, MFR, 1'b1}, got)
      u_tst.scan(1'b1, 10, {22'h0, jbs_pkg::IR_USERCODE}, got);
      `CHK("ir capture", {22'h0, jbs_pkg::IR_CAPTURE}, got)
      u_tst.scan(1'b0, 32, rnd(), got);
      `CHK("usercode", UCODE, got)
      // Bypass family, last one an unlisted code
      for (int k = 0; k < 4; k++)
      begin
         pat = rnd();
         code = (k == 3) ? {1'b1, pat[8:0]} : BYP[k];
         u_tst.scan(1'b1, 10, {22'h0, code}, got);
         u_tst.scan(1'b0, 8, pat, got);
         `CHK("bypass", byp_exp(pat[7:0]), got[7:0])
         if (code == jbs_pkg::IR_HIGHZ)
         begin
            `CHK("float", 8'h00, pin_oe)
            `CHK("keeper", hold_en, pin_keep)
         end
         else if (code != jbs_pkg::IR_CLAMP)
            `CHK("normal pins", core_out, pin_out)
      end
      u_tst.scan(1'b1, 10, {22'h0, jbs_pkg::IR_SAMPLE}, got);
      pat = rnd();
      u_tst.scan(1'b0, 24, pat, got);
      `CHK("sample", {pin_in, core_oe, core_out}, got[23:0])
      `CHK("sample pins", core_out, pin_out)
      u_tst.scan(1'b1, 10, {22'h0, jbs_pkg::IR_EXTEST}, got);
      settle();
      `CHK("extest drive", pat[7:0], pin_out)
      `CHK("extest enable", pat[15:8], pin_oe)
      // Same pattern shifted again, so the update leaves the pins as they are
      u_tst.scan(1'b0, 24, pat, got);
      `CHK("extest capture", pin_in, got[23:16])
      u_tst.scan(1'b1, 10, {22'h0, jbs_pkg::IR_CLAMP}, got);
      settle();
      `CHK("clamp drive", pat[7:0], pin_out)
      n_pulse = 0;
      u_tst.scan(1'b1, 10, {22'h0, jbs_pkg::IR_RECONFIG}, got);
      settle();
      `CHK("reconfig pulses", 1, n_pulse)
      for (int k = 0; k < 3; k++)
      begin
         u_tst.scan(1'b1, 10, {22'h0, VEN[k]}, got);
         pat = rnd();
         u_tst.scan(1'b0, 8, pat, got);
         `CHK("vendor select", 3'b001 << k, {ana_sel, data_sel, load_sel})
         // Loader sees the last bit shifted under the data code
         if (k == 1)
            `CHK("cfg bit", pat[7], shift_bit)
      end
      // Pin standard load in the middle of a running configuration
      @(posedge core_clk) cfg_busy <= 1'b1;
      u_tst.scan(1'b1, 10, {22'h0, jbs_pkg::IR_IOSTD}, got);
      settle();
      `CHK("abort", 1'b1, cfg_abort)
      `CHK("status low", 1'b1, status_oe)
      pat = rnd();
      u_tst.scan(1'b0, 16, pat, got);
      settle();
      `CHK("io standard", pat[15:0], io_std)
      u_tst.scan(1'b1, 10, {22'h0, jbs_pkg::IR_BYPASS}, got);
      @(posedge core_clk) cfg_busy <= 1'b0;
      settle();
      `CHK("status kept", 1'b1, status_oe)
      @(posedge core_clk) cfg_done <= 1'b1;
      @(posedge core_clk) cfg_done <= 1'b0;
      settle();
      `CHK("status freed", 1'b0, status_oe)
      // Mode-driven reset brings identification back
      u_tst.to_idle();
      u_tst.scan(1'b0, 32, rnd(), got);
      `CHK("idcode again", {VER, PART, MFR, 1'b1}, got)
      report_and_stop();
   end
endmodule

`default_nettype wire
